// file: hw/decode_pkg.sv
// Shared constants and types for the instruction decode and timing front end
package decode_pkg;

    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int BSEL_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int CLKS_PER_INSTR = 4;

    // Field positions inside the instruction word
    localparam int GROUP_MSB = 13;
    localparam int GROUP_LSB = 12;
    localparam int SUBOP_MSB = 11;
    localparam int SUBOP_LSB = 8;
    localparam int DEST_POS = 7;
    localparam int BSEL_MSB = 9;
    localparam int BSEL_LSB = 7;
    localparam int BITOP_MSB = 11;
    localparam int BITOP_LSB = 10;
    localparam int JUMP_POS = 11;

    // Top two bits: instruction group
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;

    // Byte group sub-opcodes that need special handling
    localparam logic [3:0] SUB_MISC = 4'h0;
    localparam logic [3:0] SUB_CLEAR = 4'h1;

    // Bit group operations
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_TSTC = 2'h2;
    localparam logic [1:0] BIT_TSTS = 2'h3;

    // Skip-capable byte sub-opcodes
    localparam logic [3:0] SUB_DECSKIP = 4'hB;
    localparam logic [3:0] SUB_INCSKIP = 4'hF;

    // Literal group: return-with-literal prefix in bits 11:10
    localparam logic [1:0] LIT_RETURN = 2'h1;

    // Low byte of control words inside the misc group (bits 7:0)
    localparam logic [7:0] CTL_RETURN = 8'h08;
    localparam logic [7:0] CTL_RETINT = 8'h09;
    localparam logic [7:0] CTL_OPTLOAD = 8'h62;
    localparam logic [7:0] CTL_SLEEP = 8'h63;
    localparam logic [7:0] CTL_WDCLR = 8'h64;
    localparam logic [7:0] CTL_DIRLOAD_LO = 8'h65;
    localparam logic [7:0] CTL_DIRLOAD_HI = 8'h67;
    localparam logic [7:0] CTL_NOP_MASK = 8'h9F;

    typedef enum logic [1:0] {CAT_BYTE, CAT_BIT, CAT_LITCTRL} cat_t;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;

endpackage

// file: hw/instr_field_decode.sv
// Combinational field split and classification of one instruction word
`timescale 1ns/100ps
module instr_field_decode
    import decode_pkg::*;
(
    input wire logic [INSTR_W-1:0] word,
    output cat_t category,
    output logic [FADDR_W-1:0] fileAddr,
    output logic destFile,
    output logic [BSEL_W-1:0] bitSel,
    output logic [LIT8_W-1:0] lit8,
    output logic [LIT11_W-1:0] lit11,
    output logic namesFile,
    output logic writesFile,
    output logic writesW,
    output logic isSkip,
    output logic isJump,
    output logic isReserved,
    output logic isLegacy
);
    logic [1:0] grp;
    logic [3:0] sub;
    logic [1:0] bop;
    logic [7:0] low;

    // Only meaningful bits are looked at; don't-care positions never enter a compare
    always_comb
    begin
        grp = word[GROUP_MSB:GROUP_LSB];
        sub = word[SUBOP_MSB:SUBOP_LSB];
        bop = word[BITOP_MSB:BITOP_LSB];
        low = word[7:0];
        fileAddr = word[FADDR_W-1:0];
        destFile = word[DEST_POS];
        bitSel = word[BSEL_MSB:BSEL_LSB];
        lit8 = word[LIT8_W-1:0];
        lit11 = word[LIT11_W-1:0];
        category = CAT_LITCTRL;
        namesFile = 1'b0;
        writesFile = 1'b0;
        writesW = 1'b0;
        isSkip = 1'b0;
        isJump = 1'b0;
        isReserved = 1'b0;
        isLegacy = 1'b0;
        if (grp == GRP_BYTE)
        begin
            category = CAT_BYTE;
            if (sub == SUB_MISC)
            begin
                if (destFile)
                begin
                    namesFile = 1'b1;
                    writesFile = 1'b1;
                    category = CAT_BYTE;
                end
                else
                begin
                    category = CAT_LITCTRL;
                    isJump = (low == CTL_RETURN) || (low == CTL_RETINT);
                    isLegacy = (low == CTL_OPTLOAD) || (low >= CTL_DIRLOAD_LO && low <= CTL_DIRLOAD_HI);
                    isReserved = !isJump && !isLegacy && low != CTL_SLEEP && low != CTL_WDCLR
                        && (low & CTL_NOP_MASK) != 8'h00;
                end
            end
            else if (sub == SUB_CLEAR && !destFile)
                writesW = 1'b1; // Clear of W touches no file
            else
            begin
                namesFile = 1'b1;
                writesFile = destFile;
                writesW = !destFile;
                isSkip = (sub == SUB_DECSKIP) || (sub == SUB_INCSKIP);
            end
        end
        else if (grp == GRP_BIT)
        begin
            category = CAT_BIT;
            namesFile = 1'b1;
            writesFile = (bop == BIT_CLR) || (bop == BIT_SET);
            isSkip = (bop == BIT_TSTC) || (bop == BIT_TSTS);
        end
        else if (grp == GRP_JUMP)
            isJump = 1'b1;
        else
        begin
            writesW = 1'b1;
            isJump = (bop == LIT_RETURN);
        end
    end
endmodule

// file: hw/instr_decode_timing.sv
// Instruction decode and four-phase execution sequencer
`timescale 1ns/100ps
module instr_decode_timing
    import decode_pkg::*;
#(
    parameter int WORD_W = INSTR_W,
    parameter logic [FADDR_W-1:0] PC_LOW_ADDR = 7'h02,
    parameter logic [FADDR_W-1:0] FIRST_PORT_ADDR = 7'h05,
    parameter logic [FADDR_W-1:0] SECOND_PORT_ADDR = 7'h06
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WORD_W-1:0] instrWord,
    input wire logic condTrue,
    output phase_t phase_q,
    output logic cycleStart_q,
    output logic execValid_q,
    output cat_t category_q,
    output logic [FADDR_W-1:0] fileAddr_q,
    output logic destFile_q,
    output logic [BSEL_W-1:0] bitSel_q,
    output logic [LIT8_W-1:0] lit8_q,
    output logic [LIT11_W-1:0] lit11_q,
    output logic fileReadStb_q,
    output logic readPins_q,
    output logic fileWriteStb_q,
    output logic wWriteStb_q,
    output logic pcLoad_q,
    output logic skipTaken_q,
    output logic nopCycle_q,
    output logic reservedOp_q,
    output logic legacyOp_q
);
    if (WORD_W != INSTR_W)
    begin : g_widthCheck
        $error("instr_decode_timing: word width must be 14");
    end
    if (PC_LOW_ADDR == FIRST_PORT_ADDR || PC_LOW_ADDR == SECOND_PORT_ADDR)
    begin : g_addrCheck
        $error("instr_decode_timing: program counter address overlaps a port");
    end

    function automatic logic isPort(input logic [FADDR_W-1:0] a);
        isPort = (a == FIRST_PORT_ADDR) || (a == SECOND_PORT_ADDR);
    endfunction

    cat_t decCat;
    logic [FADDR_W-1:0] decAddr;
    logic decDest;
    logic [BSEL_W-1:0] decBit;
    logic [LIT8_W-1:0] decLit8;
    logic [LIT11_W-1:0] decLit11;
    logic decNames;
    logic decWrFile;
    logic decWrW;
    logic decSkip;
    logic decJump;
    logic decRsv;
    logic decLegacy;

    instr_field_decode u_fields (
        .word(instrWord[INSTR_W-1:0]),
        .category(decCat),
        .fileAddr(decAddr),
        .destFile(decDest),
        .bitSel(decBit),
        .lit8(decLit8),
        .lit11(decLit11),
        .namesFile(decNames),
        .writesFile(decWrFile),
        .writesW(decWrW),
        .isSkip(decSkip),
        .isJump(decJump),
        .isReserved(decRsv),
        .isLegacy(decLegacy)
    );

    logic namesFile_q;
    logic writesFile_q;
    logic writesW_q;
    logic isSkip_q;
    logic isJump_q;
    logic rstCycle_q;
    logic twoCycle_d;
    logic endCycle;
    phase_t phase_d;

    assign endCycle = (phase_q == Q4);

    // Phase sequencer: every rising sys_clk edge advances one quarter of a cycle
    always_comb
    begin
        case (phase_q)
            Q1: phase_d = Q2;
            Q2: phase_d = Q3;
            Q3: phase_d = Q4;
            Q4: phase_d = Q1;
            default: phase_d = Q1;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_q <= Q1;
            cycleStart_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            cycleStart_q <= (phase_d == Q1);
        end
    end

    // A jump, a taken skip, or a write landing on the program counter costs a second cycle
    assign twoCycle_d = execValid_q && (isJump_q || (writesFile_q && fileAddr_q == PC_LOW_ADDR)
        || (isSkip_q && condTrue));

    // Word capture at the close of each cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            category_q <= CAT_BYTE;
            fileAddr_q <= '0;
            destFile_q <= 1'b0;
            bitSel_q <= '0;
            lit8_q <= '0;
            lit11_q <= '0;
            namesFile_q <= 1'b0;
            writesFile_q <= 1'b0;
            writesW_q <= 1'b0;
            isSkip_q <= 1'b0;
            isJump_q <= 1'b0;
            reservedOp_q <= 1'b0;
            legacyOp_q <= 1'b0;
        end
        else if (endCycle)
        begin
            category_q <= decCat;
            fileAddr_q <= decAddr;
            destFile_q <= decDest;
            bitSel_q <= decBit;
            lit8_q <= decLit8;
            lit11_q <= decLit11;
            namesFile_q <= decNames;
            writesFile_q <= decWrFile;
            writesW_q <= decWrW;
            isSkip_q <= decSkip;
            isJump_q <= decJump;
            // Flags only; behaviour on these words is left undefined
            reservedOp_q <= decRsv;
            legacyOp_q <= decLegacy;
        end
    end

    // Flush control: the word fetched during a taken branch is discarded
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            execValid_q <= 1'b0;
            nopCycle_q <= 1'b0;
            pcLoad_q <= 1'b0;
            skipTaken_q <= 1'b0;
        end
        else
        begin
            pcLoad_q <= endCycle && execValid_q && !isSkip_q && twoCycle_d;
            skipTaken_q <= endCycle && execValid_q && isSkip_q && condTrue;
            if (endCycle)
            begin
                // First cycle after reset carries no fetched word yet
                execValid_q <= !twoCycle_d && !rstCycle_q;
                nopCycle_q <= twoCycle_d;
            end
        end
    end

    // Word taken at the first cycle end after reset is dropped, as memory may not be ready yet
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rstCycle_q <= 1'b1;
        else if (endCycle)
            rstCycle_q <= 1'b0;
    end

    // Read in Q2, write in Q4, so every file register written has been read first
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fileReadStb_q <= 1'b0;
            readPins_q <= 1'b0;
            fileWriteStb_q <= 1'b0;
            wWriteStb_q <= 1'b0;
        end
        else
        begin
            fileReadStb_q <= (phase_q == Q1) && execValid_q && namesFile_q;
            readPins_q <= (phase_q == Q1) && execValid_q && namesFile_q && isPort(fileAddr_q);
            fileWriteStb_q <= (phase_q == Q3) && execValid_q && writesFile_q;
            wWriteStb_q <= (phase_q == Q3) && execValid_q && writesW_q;
        end
    end

    property p_fourPhase;
        @(posedge sys_clk) disable iff (rst)
        cycleStart_q |=> !cycleStart_q [*3] ##1 cycleStart_q;
    endproperty
    a_fourPhase: assert property (p_fourPhase) else $error("cycle is not four clocks");

    property p_readBeforeWrite;
        @(posedge sys_clk) disable iff (rst)
        fileWriteStb_q |-> $past(fileReadStb_q, 2);
    endproperty
    a_readBeforeWrite: assert property (p_readBeforeWrite) else $error("file written without read");

    property p_nopQuiet;
        @(posedge sys_clk) disable iff (rst)
        nopCycle_q |-> !fileReadStb_q && !fileWriteStb_q && !wWriteStb_q && !execValid_q;
    endproperty
    a_nopQuiet: assert property (p_nopQuiet) else $error("flush cycle performed work");

    property p_skipTwoCycles;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && execValid_q && isSkip_q && condTrue) |=> nopCycle_q [*4] ##1 !nopCycle_q;
    endproperty
    a_skipTwoCycles: assert property (p_skipTwoCycles) else $error("taken skip not one flush");

    property p_plainOneCycle;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && execValid_q && !isJump_q && !isSkip_q && !writesFile_q) |=> !nopCycle_q;
    endproperty
    a_plainOneCycle: assert property (p_plainOneCycle) else $error("plain op took two cycles");

    property p_destSelect;
        @(posedge sys_clk) disable iff (rst)
        (wWriteStb_q && category_q == CAT_BYTE && namesFile_q) |-> !destFile_q && !fileWriteStb_q;
    endproperty
    a_destSelect: assert property (p_destSelect) else $error("destination select ignored");

    property p_pinRead;
        @(posedge sys_clk) disable iff (rst)
        (fileReadStb_q && isPort(fileAddr_q)) |-> readPins_q ##2 (fileWriteStb_q == writesFile_q);
    endproperty
    a_pinRead: assert property (p_pinRead) else $error("port read did not use pins");

    property p_fieldCapture;
        @(posedge sys_clk) disable iff (rst)
        endCycle |=> fileAddr_q == $past(instrWord[6:0]) && lit11_q == $past(instrWord[10:0])
            && bitSel_q == $past(instrWord[9:7]);
    endproperty
    a_fieldCapture: assert property (p_fieldCapture) else $error("operand fields misplaced");

    property p_category;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && instrWord[13:12] == GRP_BIT) |=> category_q == CAT_BIT && namesFile_q;
    endproperty
    a_category: assert property (p_category) else $error("bit op misclassified");

    property p_jumpTwoCycles;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && execValid_q && isJump_q) |=> pcLoad_q && nopCycle_q && !execValid_q;
    endproperty
    a_jumpTwoCycles: assert property (p_jumpTwoCycles) else $error("jump did not flush one cycle");

    property p_skipNotTaken;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && execValid_q && isSkip_q && !condTrue && fileAddr_q != PC_LOW_ADDR)
            |=> !nopCycle_q && !skipTaken_q;
    endproperty
    a_skipNotTaken: assert property (p_skipNotTaken) else $error("untaken skip flushed");

    property p_readPhase;
        @(posedge sys_clk) disable iff (rst)
        fileReadStb_q |-> phase_q == Q2 && execValid_q && namesFile_q;
    endproperty
    a_readPhase: assert property (p_readPhase) else $error("file read outside Q2");

    property p_writePhase;
        @(posedge sys_clk) disable iff (rst)
        (fileWriteStb_q || wWriteStb_q) |-> phase_q == Q4 && execValid_q;
    endproperty
    a_writePhase: assert property (p_writePhase) else $error("result stored outside Q4");

    property p_literalGroup;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && instrWord[GROUP_MSB]) |=> category_q == CAT_LITCTRL && !namesFile_q && !writesFile_q;
    endproperty
    a_literalGroup: assert property (p_literalGroup) else $error("literal op misclassified");

    property p_dontCare;
        @(posedge sys_clk) disable iff (rst)
        (endCycle && instrWord[13:7] == 7'h02) |=> category_q == CAT_BYTE && writesW_q && !namesFile_q;
    endproperty
    a_dontCare: assert property (p_dontCare) else $error("don't-care bits changed decode");

endmodule

// file: bench/prog_mem_model.sv
// Program memory model that hands the core one instruction word per instruction cycle
`timescale 1ns/100ps
module prog_mem_model
    import decode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire phase_t phase_q,
    output logic [INSTR_W-1:0] instrWord
);
    logic [INSTR_W-1:0] fifo[$];

    initial instrWord = 14'h0000;

    task automatic push(input logic [INSTR_W-1:0] w);
        fifo.push_back(w);
        instrWord = fifo[0];
    endtask

    // A word is held until the edge that ends Q4 has taken it
    always @(posedge sys_clk)
    begin
        if (!rst && phase_q == Q4)
        begin
            #1;
            if (fifo.size() > 0)
                fifo.pop_front();
            // Idle fetches return a plain no-operation word, never an unassigned or legacy code
            instrWord = (fifo.size() > 0) ? fifo[0] : 14'h0000;
        end
    end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the instruction decode and timing front end
`timescale 1ns/100ps
module tb_top;
    import decode_pkg::*;
    logic sys_clk, rst, condTrue, cycleStart_q, execValid_q, destFile_q;
    logic fileReadStb_q, readPins_q, fileWriteStb_q, wWriteStb_q, pcLoad_q, skipTaken_q;
    logic nopCycle_q, reservedOp_q, legacyOp_q, seenLegacy, seenReserved;
    logic [INSTR_W-1:0] instrWord;
    logic [FADDR_W-1:0] fileAddr_q;
    logic [BSEL_W-1:0] bitSel_q;
    logic [LIT8_W-1:0] lit8_q;
    logic [LIT11_W-1:0] lit11_q;
    phase_t phase_q;
    cat_t category_q;
    int cycles = 0;
    int mismatches = 0;
    int checks_done = 0;

    instr_decode_timing dut_u (.sys_clk, .rst, .instrWord, .condTrue, .phase_q, .cycleStart_q,
        .execValid_q, .category_q, .fileAddr_q, .destFile_q, .bitSel_q, .lit8_q, .lit11_q,
        .fileReadStb_q, .readPins_q, .fileWriteStb_q, .wWriteStb_q, .pcLoad_q, .skipTaken_q,
        .nopCycle_q, .reservedOp_q, .legacyOp_q);
    prog_mem_model mem_u (.sys_clk, .rst, .phase_q, .instrWord);

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_phase(input phase_t p);
        do
        begin
            @(posedge sys_clk);
            #1;
        end
        while (phase_q !== p);
    endtask

    // e = {read, pins, fileWrite, wWrite, pcLoad, skip}; word pushed mid-cycle, away from the sampling edge
    task automatic run_word(input logic [INSTR_W-1:0] w, input logic c, input cat_t cat, input logic [5:0] e);
        logic [3:0] rv, pv, fv, wv;
        logic stb, nop;
        wait_phase(Q2);
        mem_u.push(w);
        condTrue = c;
        wait_phase(Q1);
        seenLegacy = legacyOp_q;
        seenReserved = reservedOp_q;
        chk("category", 16'(category_q), 16'(cat));
        chk("execValid", 16'(execValid_q), 16'h0001);
        chk("cycleStart", 16'(cycleStart_q), 16'h0001);
        chk("fileAddrDest", 16'({destFile_q, fileAddr_q}), 16'(w[7:0]));
        chk("bitSel", 16'(bitSel_q), 16'(w[9:7]));
        chk("lit8", 16'(lit8_q), 16'(w[7:0]));
        chk("lit11", 16'(lit11_q), 16'(w[10:0]));
        for (int i = 0; i < 4; i++)
        begin
            chk("phase", 16'(phase_q), 16'(i));
            rv[i] = fileReadStb_q;
            pv[i] = readPins_q;
            fv[i] = fileWriteStb_q;
            wv[i] = wWriteStb_q;
            @(posedge sys_clk);
            #1;
        end
        condTrue = 1'b0;
        chk("readStb", 16'(rv), 16'({e[5], 1'b0}));
        chk("readPins", 16'(pv), 16'({e[4], 1'b0}));
        chk("fileWrite", 16'(fv), 16'({e[3], 3'b000}));
        chk("wWrite", 16'(wv), 16'({e[2], 3'b000}));
        chk("pcLoad", 16'(pcLoad_q), 16'(e[1]));
        chk("skipTaken", 16'(skipTaken_q), 16'(e[0]));
        chk("nopCycle", 16'(nopCycle_q), 16'(e[1] | e[0]));
        if (e[1] | e[0])
        begin
            stb = 1'b0;
            nop = 1'b1;
            repeat (4)
            begin
                stb = stb | fileReadStb_q | fileWriteStb_q | wWriteStb_q | execValid_q;
                nop = nop & nopCycle_q;
                @(posedge sys_clk);
                #1;
            end
            chk("flushQuiet", 16'({stb, nop}), 16'h0001);
        end
    endtask

    task automatic t_byte();
        logic [3:0] subs[12] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE};
        foreach (subs[i])
            run_word({2'b00, subs[i], 8'hA1}, 1'b0, CAT_BYTE, 6'b101000);
        run_word(14'h07FF, 1'b1, CAT_BYTE, 6'b101000);
        run_word(14'h0700, 1'b0, CAT_BYTE, 6'b100100);
        run_word(14'h00A0, 1'b0, CAT_BYTE, 6'b101000);
        run_word(14'h017F, 1'b0, CAT_BYTE, 6'b000100);
        $display("done t_byte");
    endtask

    task automatic t_port();
        run_word(14'h0186, 1'b0, CAT_BYTE, 6'b111000);
        run_word(14'h0885, 1'b0, CAT_BYTE, 6'b111000);
        run_word(14'h1386, 1'b0, CAT_BIT, 6'b111000);
        run_word(14'h16A5, 1'b0, CAT_BIT, 6'b101000);
        $display("done t_port");
    endtask

    task automatic t_skip();
        run_word(14'h1C03, 1'b1, CAT_BIT, 6'b100001);
        run_word(14'h1C03, 1'b0, CAT_BIT, 6'b100000);
        run_word(14'h1803, 1'b1, CAT_BIT, 6'b100001);
        run_word(14'h0BA0, 1'b1, CAT_BYTE, 6'b101001);
        run_word(14'h0F20, 1'b0, CAT_BYTE, 6'b100100);
        $display("done t_skip");
    endtask

    task automatic t_ctrl();
        logic [INSTR_W-1:0] lits[7] = '{14'h30A5, 14'h33A5, 14'h3EFF, 14'h3900, 14'h3C00, 14'h3800, 14'h3A00};
        foreach (lits[i])
            run_word(lits[i], 1'b0, CAT_LITCTRL, 6'b000100);
        run_word(14'h2DA5, 1'b0, CAT_LITCTRL, 6'b000010);
        run_word(14'h25A5, 1'b0, CAT_LITCTRL, 6'b000010);
        run_word(14'h0008, 1'b0, CAT_LITCTRL, 6'b000010);
        run_word(14'h0009, 1'b0, CAT_LITCTRL, 6'b000010);
        run_word(14'h34A5, 1'b0, CAT_LITCTRL, 6'b000110);
        run_word(14'h0082, 1'b0, CAT_BYTE, 6'b101010);
        run_word(14'h0060, 1'b1, CAT_LITCTRL, 6'b000000);
        run_word(14'h0063, 1'b0, CAT_LITCTRL, 6'b000000);
        run_word(14'h0064, 1'b0, CAT_LITCTRL, 6'b000000);
        run_word(14'h0062, 1'b0, CAT_LITCTRL, 6'b000000);
        chk("legacyOpt", 16'(seenLegacy), 16'h0001);
        run_word(14'h0065, 1'b0, CAT_LITCTRL, 6'b000000);
        chk("legacyDir", 16'(seenLegacy), 16'h0001);
        run_word(14'h0001, 1'b0, CAT_LITCTRL, 6'b000000);
        chk("reserved", 16'({seenReserved, seenLegacy}), 16'h0002);
        $display("done t_ctrl");
    endtask

    // The word taken at the first cycle end after release is dropped, so stimulus starts a cycle later
    task automatic t_reset();
        rst = 1'b1;
        condTrue = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        chk("resetPhase", 16'({execValid_q, phase_q}), 16'(Q1));
        chk("resetStb", 16'({fileReadStb_q, readPins_q, fileWriteStb_q, wWriteStb_q}), 16'h0000);
        chk("resetFlow", 16'({pcLoad_q, skipTaken_q, nopCycle_q, cycleStart_q}), 16'h0000);
        chk("resetCat", 16'({category_q, reservedOp_q, legacyOp_q}), 16'({CAT_BYTE, 2'b00}));
        rst = 1'b0;
        wait_phase(Q1);
        chk("deadCycle", 16'({cycleStart_q, execValid_q}), 16'h0002);
        $display("done t_reset");
    endtask

    initial
    begin
        t_reset();
        t_byte();
        t_port();
        t_reset();
        t_skip();
        t_ctrl();
        final_report();
    end
endmodule
